// ### als_regs.svh
// register offsets, field positions, reset values and timing counts of the lamp sequencer
`ifndef ALS_REGS_SVH
`define ALS_REGS_SVH
`define ALS_OFF_CTRL         8'h00
`define ALS_OFF_STATUS       8'h04
`define ALS_OFF_FILTER       8'h08
`define ALS_OFF_TIME         8'h0C
`define ALS_CTRL_THR_LSB     0
`define ALS_CTRL_EN_LSB      8
`define ALS_THR_RESET        8'h80
`define ALS_EN_RESET         2'h3
`define ALS_CLK_NS           8
`define ALS_TICK_NS          1000000
`define ALS_TICK_CYCLES      (`ALS_TICK_NS / `ALS_CLK_NS)
`define ALS_SAMPLE_MASK      7'h7F
`define ALS_TICKS_PER_SEC    16'h03E7
`define ALS_FILTER_MAX       8'hFF
`define ALS_FILTER_MIN       8'h00
`define ALS_DELAY_OFF_LEVEL  8'h04
`define ALS_DUR_SCALE        6'h2D
`define ALS_DUR_SHIFT        6
`define ALS_RESP_OKAY        2'h0
`define ALS_RESP_SLVERR      2'h2
`endif

// ### als_pkg.sv
// types shared by the lamp sequencer
package als_pkg;
    // sequencer states
    typedef enum logic [2:0] {
        ALS_INIT  = 3'h0,
        ALS_READ  = 3'h1,
        ALS_SENSE = 3'h2,
        ALS_DELAY = 3'h3,
        ALS_SLEEP = 3'h4
    } als_state_t;
    // status word read back by software
    typedef struct packed {
        logic [22:0] zero;
        logic        change_flag;
        logic        auto_en;
        logic        delay_active;
        logic [1:0]  lamp;
        logic        dark;
        als_state_t  state;
    } als_status_t;
    // analog readings carried together
    typedef struct packed {
        logic [7:0] light;
        logic [7:0] delay;
    } als_analog_t;
endpackage

// ### als_lamp_sequencer.sv
// automatic exterior lamp sequencer with an axi4-lite register slave
// Overview of operation
// - ignition on: sense light, drive lamps
// - ignition off while sensing: go delay handling
// - lamps lit: hold for delay, off, sleep
// - no lamp lit: sleep at once
// - nothing pending: arm change detect, sleep
// - input change in sleep restarts from init
// - reset or wake: full init, clear flags
// - wake reading dark: lamps on immediately, sense
// - each timer tick bumps 16-bit time
// - awake input change only clears flags
// - sample light every 128 ms tick
// - filter counts up dark, down bright, saturating
// - dark flag set at 255, cleared at 0
// - delay counter steps once per second
// - count reaches duration: delay flag cleared
// - light reading comes from channel 0
// - delay setting comes from channel 1
// - light threshold is software programmable
// - two independently controlled lamp channels
// - delay knob off disables automatic control
// - delay spans two seconds to ~3 minutes
`timescale 1ns/10ps
`include "als_regs.svh"
module als_lamp_sequencer #(
    parameter int P_TICK_CYCLES = `ALS_TICK_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_ignition,
    input  wire logic        i_wake_pin,
    input  wire logic [7:0]  i_adc_ch0,
    input  wire logic [7:0]  i_adc_ch1,
    output logic [1:0]       o_lamp,
    output logic             o_sleep,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready
);
    localparam int TW = $clog2(P_TICK_CYCLES);

    // elaboration check: the tick divider needs at least two cycles
    if (P_TICK_CYCLES < 2) begin : g_chk
        $error("tick period must be at least two clock cycles");
    end

    als_pkg::als_state_t  state_q;          // sequencer state
    als_pkg::als_analog_t adc;              // both analog channels
    logic [TW-1:0]        tick_cnt_q;       // clock cycles within one timer tick
    logic                 tick;             // periodic timer event
    logic [15:0]          sys_time_q;       // free running system time
    logic [15:0]          sec_mark_q;       // time value at the last second boundary
    logic                 tick128;          // 128 ms sample point
    logic                 sec_tick;         // one second point
    logic                 ign_meta_q;       // synchroniser first stage
    logic                 ign_q;            // synchronised ignition
    logic                 wake_prev_q;      // wake pin one cycle back
    logic                 ign_prev_q;       // ignition one cycle back
    logic                 pin_change;       // any monitored pin moved
    logic                 change_flag_q;    // pin change flag, held only during sleep
    logic [7:0]           filter_q;         // light filter counter
    logic                 dark_q;           // dark_state_flag
    logic [1:0]           lamp_q;           // lamp relay drive per channel
    logic [7:0]           delay_cnt_q;      // seconds spent in delay handling
    logic                 delay_active_q;   // delay still running
    logic [13:0]          dur_prod;         // scaled delay knob
    logic [7:0]           duration;         // delay in seconds
    logic                 dark_sample;      // reading below threshold
    logic                 auto_en;          // knob not in off position
    logic [7:0]           thr_q;            // programmable light threshold
    logic [1:0]           chan_en_q;        // per channel enable

    // channel 0 carries the photocell, channel 1 the delay knob
    assign adc.light   = i_adc_ch0;
    assign adc.delay   = i_adc_ch1;
    assign dark_sample = adc.light < thr_q;
    assign auto_en     = adc.delay >= `ALS_DELAY_OFF_LEVEL;
    // knob full scale maps to 179 s, knob minimum to zero seconds
    assign dur_prod    = 14'(adc.delay) * 14'(`ALS_DUR_SCALE);
    assign duration    = dur_prod[13:6];

    // timer divider: one tick per millisecond
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end
    assign tick = tick_cnt_q == TW'(P_TICK_CYCLES - 1);

    // system time counter, wraps freely
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sys_time_q <= 16'h0000;
        end else if (tick) begin
            sys_time_q <= sys_time_q + 16'h0001;
        end
    end

    // both scheduler ticks derive from the time counter
    assign tick128  = tick && (sys_time_q[6:0] == `ALS_SAMPLE_MASK);
    assign sec_tick = tick && ((sys_time_q - sec_mark_q) == `ALS_TICKS_PER_SEC);

    // second boundary tracker; survives counter wrap by using a difference
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sec_mark_q <= 16'h0000;
        end else if (sec_tick) begin
            sec_mark_q <= sys_time_q + 16'h0001;
        end
    end

    // ignition synchroniser; only the second stage is used
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ign_meta_q <= 1'b0;
            ign_q      <= 1'b0;
        end else begin
            ign_meta_q <= i_ignition;
            ign_q      <= ign_meta_q;
        end
    end

    // previous values of the monitored pins for change detection
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ign_prev_q  <= 1'b0;
            wake_prev_q <= 1'b0;
        end else begin
            ign_prev_q  <= ign_q;
            wake_prev_q <= i_wake_pin;
        end
    end
    assign pin_change = (ign_prev_q != ign_q) || (wake_prev_q != i_wake_pin);

    // change flag: a new change wins over the clear in the same cycle
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            change_flag_q <= 1'b0;
        end else if (pin_change) begin
            change_flag_q <= 1'b1;
        end else if (state_q != als_pkg::ALS_SLEEP) begin
            change_flag_q <= 1'b0;
        end
    end

    // main sequencer
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_q <= als_pkg::ALS_INIT;
        end else begin
            case (state_q)
                als_pkg::ALS_INIT: begin
                    state_q <= als_pkg::ALS_READ;
                end
                als_pkg::ALS_READ: begin
                    state_q <= als_pkg::ALS_SENSE;
                end
                als_pkg::ALS_SENSE: begin
                    // ignition off: lit lamps need the delay, dark ones do not
                    if (!ign_q && (|lamp_q)) begin
                        state_q <= als_pkg::ALS_DELAY;
                    end else if (!ign_q) begin
                        state_q <= als_pkg::ALS_SLEEP;
                    end
                end
                als_pkg::ALS_DELAY: begin
                    // ignition back on resumes sensing without a restart
                    if (ign_q) begin
                        state_q <= als_pkg::ALS_SENSE;
                    end else if (!delay_active_q || !auto_en) begin
                        state_q <= als_pkg::ALS_SLEEP;
                    end
                end
                als_pkg::ALS_SLEEP: begin
                    if (pin_change) begin
                        state_q <= als_pkg::ALS_INIT;
                    end
                end
                default: begin
                    state_q <= als_pkg::ALS_INIT;
                end
            endcase
        end
    end

    // light filter and dark flag
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || state_q == als_pkg::ALS_INIT) begin
            filter_q <= `ALS_FILTER_MIN;
            dark_q   <= 1'b0;
        end else if (state_q == als_pkg::ALS_READ) begin
            // wake reading bypasses filtering so lamps light at once
            filter_q <= dark_sample ? `ALS_FILTER_MAX : `ALS_FILTER_MIN;
            dark_q   <= dark_sample;
        end else if (state_q == als_pkg::ALS_SENSE && tick128) begin
            if (dark_sample && filter_q != `ALS_FILTER_MAX) begin
                filter_q <= filter_q + 8'h01;
                dark_q   <= (filter_q == 8'hFE) | dark_q;
            end else if (!dark_sample && filter_q != `ALS_FILTER_MIN) begin
                filter_q <= filter_q - 8'h01;
                dark_q   <= (filter_q != 8'h01) & dark_q;
            end
        end
    end

    // lamp relays: low from reset, follow dark flag while sensing
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || state_q == als_pkg::ALS_INIT || state_q == als_pkg::ALS_SLEEP) begin
            lamp_q <= 2'h0;
        end else if (state_q == als_pkg::ALS_READ) begin
            lamp_q <= (dark_sample && auto_en) ? chan_en_q : 2'h0;
        end else if (state_q == als_pkg::ALS_SENSE) begin
            // each channel gated by its own enable bit
            // ignition off with dark lamps must not light them on the way to sleep
            lamp_q <= (dark_q && auto_en && (ign_q || (|lamp_q))) ? chan_en_q : 2'h0;
        end else if (!auto_en || (!ign_q && !delay_active_q)) begin
            // lamps drop on the same edge that delay handling goes to sleep
            lamp_q <= 2'h0;
        end
    end

    // delay counter and delay flag
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || state_q == als_pkg::ALS_INIT) begin
            delay_cnt_q    <= 8'h00;
            delay_active_q <= 1'b0;
        end else if (state_q == als_pkg::ALS_SENSE) begin
            // armed only while sensing, so an expired flag stays clear in sleep
            delay_cnt_q    <= 8'h00;
            delay_active_q <= duration != 8'h00;
        end else if (state_q == als_pkg::ALS_DELAY && sec_tick && delay_active_q) begin
            delay_cnt_q    <= delay_cnt_q + 8'h01;
            if ((delay_cnt_q + 8'h01) >= duration) begin
                delay_active_q <= 1'b0;
            end
        end
    end

    assign o_lamp  = lamp_q;
    assign o_sleep = state_q == als_pkg::ALS_SLEEP;

    // axi4-lite write side: address and data held until both present
    logic        aw_held_q;   // write address captured
    logic        w_held_q;    // write data captured
    logic [7:0]  awaddr_q;    // captured write address
    logic [31:0] wdata_q;     // captured write data
    logic [3:0]  wstrb_q;     // captured byte enables
    logic        bvalid_q;    // write response pending
    logic [1:0]  bresp_q;     // write response code
    logic        do_write;    // both halves present

    assign o_awready = !aw_held_q && !bvalid_q;
    assign o_wready  = !w_held_q && !bvalid_q;
    assign do_write  = aw_held_q && w_held_q && !bvalid_q;
    assign o_bvalid  = bvalid_q;
    assign o_bresp   = bresp_q;

    // capture each half of a write independently
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= i_awaddr;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // write response; only the control word is writable
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `ALS_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (awaddr_q[7:2] == 6'(`ALS_OFF_CTRL >> 2)) ? `ALS_RESP_OKAY : `ALS_RESP_SLVERR;
        end else if (i_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // control register: threshold in byte 0, channel enables in byte 1
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            thr_q     <= `ALS_THR_RESET;
            chan_en_q <= `ALS_EN_RESET;
        end else if (do_write && awaddr_q[7:2] == 6'(`ALS_OFF_CTRL >> 2)) begin
            if (wstrb_q[0]) begin
                thr_q <= wdata_q[`ALS_CTRL_THR_LSB +: 8];
            end
            if (wstrb_q[1]) begin
                chan_en_q <= wdata_q[`ALS_CTRL_EN_LSB +: 2];
            end
        end
    end

    // axi4-lite read side: one read outstanding, data registered
    logic                 rvalid_q;   // read data pending
    logic [31:0]          rdata_q;    // read data
    logic [1:0]           rresp_q;    // read response code
    als_pkg::als_status_t status;     // live status word
    logic [31:0]          rd_word;    // decoded read value
    logic                 rd_hit;     // address is mapped

    assign o_arready = !rvalid_q;
    assign o_rvalid  = rvalid_q;
    assign o_rdata   = rdata_q;
    assign o_rresp   = rresp_q;

    // status word shows the sequencer's own state
    always_comb begin
        status              = '0;
        status.state        = state_q;
        status.dark         = dark_q;
        status.lamp         = lamp_q;
        status.delay_active = delay_active_q;
        status.auto_en      = auto_en;
        status.change_flag  = change_flag_q;
    end

    // read decode; unmapped words read zero with slverr
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (i_araddr[7:2])
            6'(`ALS_OFF_CTRL >> 2):   rd_word = {22'h000000, chan_en_q, thr_q};
            6'(`ALS_OFF_STATUS >> 2): rd_word = status;
            6'(`ALS_OFF_FILTER >> 2): rd_word = {16'h0000, delay_cnt_q, filter_q};
            6'(`ALS_OFF_TIME >> 2):   rd_word = {16'h0000, sys_time_q};
            default:                  rd_hit  = 1'b0;
        endcase
    end

    // read response register
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `ALS_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? `ALS_RESP_OKAY : `ALS_RESP_SLVERR;
        end else if (i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // checks on the sequencer
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    // wake reading then first sensing cycle
    sequence s_wake_dark;
        state_q == als_pkg::ALS_READ && dark_sample && auto_en && chan_en_q != 2'h0;
    endsequence
    sequence s_lit_sensing;
        state_q == als_pkg::ALS_SENSE && lamp_q != 2'h0 && filter_q == `ALS_FILTER_MAX;
    endsequence
    sequence s_unlit_ign_off;
        state_q == als_pkg::ALS_SENSE && !ign_q && lamp_q == 2'h0;
    endsequence

    sleep_lamps_off_a: assert property (o_sleep |-> o_lamp == 2'h0)
        else $error("lamp driven during sleep");
    skip_delay_a: assert property (s_unlit_ign_off |=> state_q == als_pkg::ALS_SLEEP)
        else $error("unlit ignition off did not go straight to sleep");
    wake_restart_a: assert property (o_sleep && pin_change |=> state_q == als_pkg::ALS_INIT ##1
        state_q == als_pkg::ALS_READ)
        else $error("pin change in sleep did not restart");
    init_clear_a: assert property (state_q == als_pkg::ALS_INIT |=> lamp_q == 2'h0 && filter_q == 8'h00)
        else $error("init left state behind");
    time_step_a: assert property (tick |=> sys_time_q == $past(sys_time_q) + 16'h0001)
        else $error("system time did not advance on tick");
    wake_dark_a: assert property (s_wake_dark |=> s_lit_sensing)
        else $error("dark wake reading did not light lamps");
    dark_flag_a: assert property ((filter_q == 8'hFF |-> dark_q) and (filter_q == 8'h00 |-> !dark_q))
        else $error("dark flag disagrees with filter end point");
    filter_sat_a: assert property (state_q == als_pkg::ALS_SENSE && tick128 && dark_sample &&
        filter_q == 8'hFF |=> filter_q == 8'hFF)
        else $error("filter wrapped past maximum");
    delay_expire_a: assert property (state_q == als_pkg::ALS_DELAY && sec_tick && delay_active_q &&
        (delay_cnt_q + 8'h01) >= duration |=> !delay_active_q)
        else $error("delay flag not cleared at duration");
    sample_spacing_a: assert property (tick128 |=> !tick128 [*8])
        else $error("samples too close together");
endmodule

// ### als_light_env.sv
// photocell, delay knob and relay model facing the lamp sequencer
`timescale 1ns/10ps
module als_light_env (
    input  wire logic [7:0] i_light,         // level the bench asks of the photocell
    input  wire logic [7:0] i_knob,          // level the bench asks of the knob
    input  wire logic       i_clock,         // system clock
    input  wire logic [1:0] i_lamp,          // relay drive from the sequencer
    output logic [7:0]      o_adc_ch0 = 8'h00, // photocell divider reading
    output logic [7:0]      o_adc_ch1 = 8'h00, // knob wiper reading
    output logic [1:0]      o_relay   = 2'h0   // contacts closed per channel
);
    // converters settle one clock after the level moves, never mid-cycle
    always_ff @(posedge i_clock) begin
        o_adc_ch0 <= i_light;
        o_adc_ch1 <= i_knob;
    end
    // each relay follows its own drive a clock late
    always_ff @(posedge i_clock) begin
        o_relay <= i_lamp;
    end
endmodule

// ### als_lamp_sequencer_tb.sv
// self-checking bench for the lamp sequencer
`timescale 1ns/10ps
`include "als_regs.svh"
module als_lamp_sequencer_tb;
    localparam int TICK   = 4;          // short tick keeps samples 512 cycles apart
    localparam int SAMPLE = 128 * TICK; // cycles per light sample
    logic        clock, rst_n, ignition, wake_pin, sleep;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0]  light, knob, adc0, adc1, awaddr, araddr, thr;
    logic [31:0] wdata, rdata, rd;
    logic [15:0] t0;
    logic [3:0]  wstrb;
    logic [1:0]  lamp, relay, bresp, rresp, resp;
    int          cycles, num_errors, num_checks;

    als_light_env i_als_light_env (.i_light(light), .i_knob(knob), .i_clock(clock), .i_lamp(lamp),
        .o_adc_ch0(adc0), .o_adc_ch1(adc1), .o_relay(relay));
    als_lamp_sequencer #(.P_TICK_CYCLES(TICK)) i_als_lamp_sequencer (.i_clock(clock), .i_rst_n(rst_n),
        .i_ignition(ignition), .i_wake_pin(wake_pin), .i_adc_ch0(adc0), .i_adc_ch1(adc1), .o_lamp(lamp),
        .o_sleep(sleep), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));

    // free clock at 125 MHz
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // cycle count gives sample phase and cuts a hang short
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    // both write halves offered together, each released at its own taking edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_hit, w_hit, b_hit;
        @(posedge clock);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(negedge clock);
            {aw_hit, w_hit, b_hit} = {awvalid & awready, wvalid & wready, bvalid};
            resp = bresp;
            @(posedge clock);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
        end while (!b_hit);
        bready <= 1'b0;
    endtask
    // read leaves data and response in rd and resp
    task automatic axi_rd(input logic [7:0] a);
        logic ar_hit, r_hit;
        @(posedge clock);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(negedge clock);
            {ar_hit, r_hit, rd, resp} = {arvalid & arready, rvalid, rdata, rresp};
            @(posedge clock);
            if (ar_hit) arvalid <= 1'b0;
        end while (!r_hit);
        rready <= 1'b0;
    endtask
    // lamps looked at mid-cycle, clear of the edge
    task automatic chk_lamp(input string what, input logic [1:0] exp);
        @(negedge clock);
        check(what, 32'(exp), 32'(lamp));
    endtask
    task automatic wait_sleep(input logic lvl, input int n);
        for (int k = 0; k < n && sleep !== lvl; k++) @(negedge clock);
        check("sleep", 32'(lvl), 32'(sleep));
    endtask
    // lands just after a sample so the next wait spans exactly one
    task automatic to_sample();
        do @(negedge clock); while (cycles % SAMPLE != 100);
        @(posedge clock);
    endtask
    // readings strictly below the threshold count as dark, equal as bright
    function automatic logic [7:0] dark_of(input logic [7:0] t);
        return t - 8'h01 - 8'($urandom % 48);
    endfunction
    function automatic logic [7:0] bright_of(input logic [7:0] t);
        return t + 8'($urandom % 64);
    endfunction
    task automatic wrap_up();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        void'($urandom(32'hDC5F));
        {cycles, num_errors, num_checks} = '0;
        {rst_n, wake_pin, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {ignition, wstrb, light, knob} = {1'b1, 4'hF, 8'h20, `ALS_DELAY_OFF_LEVEL};
        thr = 8'h40 + 8'($urandom % 128);
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        chk_lamp("lamp after reset", 2'h0);
        axi_rd(`ALS_OFF_CTRL);
        check("ctrl reset", 32'({`ALS_EN_RESET, `ALS_THR_RESET}), rd);
        chk_lamp("lamp dark wake", 2'h3);
        axi_rd(`ALS_OFF_FILTER);
        check("filter dark wake", 32'hFF, 32'(rd[7:0]));
        axi_rd(`ALS_OFF_STATUS);
        check("dark sensing", 32'hA, 32'(rd[3:0]));
        axi_rd(8'h10);
        check("unmapped read", 32'(`ALS_RESP_SLVERR), {rd[29:0], resp});
        axi_wr(`ALS_OFF_STATUS, 32'h0);
        check("status write", 32'(`ALS_RESP_SLVERR), 32'(resp));
        axi_wr(`ALS_OFF_CTRL, {22'h0, 2'h1, thr});
        light <= dark_of(thr);
        axi_rd(`ALS_OFF_CTRL);
        check("ctrl readback", {22'h0, 2'h1, thr}, rd);
        to_sample();
        chk_lamp("one lamp enabled", 2'h1);
        check("relays", 32'h1, 32'(relay));
        axi_wr(`ALS_OFF_CTRL, {22'h0, 2'h3, thr});
        light <= bright_of(thr);
        to_sample();
        axi_rd(`ALS_OFF_FILTER);
        check("filter step down", 32'hFE, 32'(rd[7:0]));
        chk_lamp("dark flag holds", 2'h3);
        light <= dark_of(thr);
        repeat (2) to_sample();
        axi_rd(`ALS_OFF_FILTER);
        check("filter saturates", 32'hFF, 32'(rd[7:0]));
        axi_rd(`ALS_OFF_TIME);
        t0 = rd[15:0];
        // the two read takings land exactly 50 ticks apart, whatever the phase
        repeat (50 * TICK - 3) @(posedge clock);
        axi_rd(`ALS_OFF_TIME);
        check("time step", 32'(t0 + 16'h0032), 32'(rd[15:0]));
        ignition <= 1'b0;
        repeat (8) @(posedge clock);
        axi_rd(`ALS_OFF_STATUS);
        check("delay entered", 32'hB, 32'({rd[6], rd[2:0]}));
        repeat (3960) @(posedge clock);
        chk_lamp("lamp held in delay", 2'h3);
        wait_sleep(1'b1, 4200);
        chk_lamp("lamp off in sleep", 2'h0);
        axi_rd(`ALS_OFF_STATUS);
        check("delay expired", 32'h4, 32'({rd[6], rd[2:0]}));
        light <= bright_of(thr);
        wake_pin <= 1'b1;
        wait_sleep(1'b0, 8);
        wait_sleep(1'b1, 12);
        chk_lamp("lamp stays off", 2'h0);
        axi_rd(`ALS_OFF_STATUS);
        check("change flag", 32'h0, 32'(rd[8]));
        light <= dark_of(thr);
        ignition <= 1'b1;
        wait_sleep(1'b0, 8);
        repeat (8) @(posedge clock);
        wake_pin <= 1'b0;
        chk_lamp("lamp on at wake", 2'h3);
        repeat (8) @(posedge clock);
        chk_lamp("awake change", 2'h3);
        axi_rd(`ALS_OFF_STATUS);
        check("awake flag", 32'h0, 32'(rd[8]));
        wait_sleep(1'b0, 0);
        @(posedge clock);
        knob <= `ALS_DELAY_OFF_LEVEL - 8'h01;
        repeat (8) @(posedge clock);
        chk_lamp("knob off", 2'h0);
        wrap_up();
    end
endmodule
